// ---- tws_core.v ----
// two-wire interface: software-driven master and hardware byte slave
`timescale 1ns/100ps
`include "tws_regs.vh"
module tws_core #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW    = 2
) (
    // clock and reset
    input  wire       core_clk_i,
    input  wire       reset_n_i,
    input  wire       clk_en_i,
    // special-function register port
    input  wire [7:0] sfr_addr_i,
    input  wire       sfr_wr_i,
    input  wire       sfr_rd_i,
    input  wire [7:0] sfr_wdata_i,
    output reg  [7:0] sfr_rdata_o,
    // pin ownership from the peripheral control register
    input  wire       peripheral_select_i,
    // serial data pin, enable low while driven
    input  wire       serial_data_pin_i,
    output wire       serial_data_pin_o,
    output wire       serial_data_pin_oe_n_o,
    // serial clock pin, enable low while driven
    input  wire       serial_clock_pin_i,
    output wire       serial_clock_pin_o,
    output wire       serial_clock_pin_oe_n_o,
    // received byte stream, drained by the core side
    output wire       rx_valid_o,
    output wire [7:0] rx_data_o,
    input  wire       rx_ready_i
);
    // =============================================================
    // slave state codes
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_RXB  = 3'd3;
    localparam ST_RACK = 3'd4;
    localparam ST_TXB  = 3'd5;
    localparam ST_TACK = 3'd6;

    // =============================================================
    // registers
    reg  [7:0] twowire_data_reg;
    reg  [7:0] own_slave_address;
    reg        soft_master_data_out;
    reg        soft_master_data_out_enable;
    reg        soft_master_clock_out;
    reg        soft_master_data_in;
    reg        role_select;
    reg        slave_interface_reset;
    reg        slave_transmit_direction;
    reg        byte_complete_flag;

    reg  [2:0] sda_sync;
    reg  [2:0] scl_sync;
    reg        sda_q;
    reg        scl_q;
    reg  [2:0] state;
    reg  [7:0] shift;
    reg  [3:0] bit_cnt;
    reg        drive_low;
    reg        rx_push;

    wire       twi_on;
    wire       master_on;
    wire       slave_on;
    wire       sda_now;
    wire       scl_now;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_seen;
    wire       stop_seen;
    wire       data_acc;
    wire       fifo_in_ready;
    wire       byte_done;

    // decodes a register address against a strobe
    function hit;
        input [7:0] addr;
        input [7:0] target;
        input       strobe;
        begin
            hit = strobe & (addr == target);
        end
    endfunction

    assign twi_on    = ~peripheral_select_i;
    assign master_on = twi_on & role_select;
    assign slave_on  = twi_on & ~role_select & ~slave_interface_reset;
    assign data_acc  = hit(sfr_addr_i, `TWS_ADDR_DATA, sfr_wr_i) |
                       hit(sfr_addr_i, `TWS_ADDR_DATA, sfr_rd_i);

    // =============================================================
    // pin inputs: three stages, change accepted when last two agree
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_sync <= 3'h7;
            scl_sync <= 3'h7;
            sda_q    <= 1'b1;
            scl_q    <= 1'b1;
        end else if (clk_en_i) begin
            sda_sync <= {sda_sync[1:0], serial_data_pin_i};
            scl_sync <= {scl_sync[1:0], serial_clock_pin_i};
            if (sda_sync[1] == sda_sync[2]) begin
                sda_q <= sda_sync[2];
            end
            if (scl_sync[1] == scl_sync[2]) begin
                scl_q <= scl_sync[2];
            end
        end
    end

    assign sda_now    = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
    assign scl_now    = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
    assign scl_rise   = scl_now & ~scl_q;
    assign scl_fall   = ~scl_now & scl_q;
    assign start_seen = scl_now & scl_q & sda_q & ~sda_now;
    assign stop_seen  = scl_now & scl_q & ~sda_q & sda_now;

    // =============================================================
    // pin drivers, open drain style for the slave
    // only these two pins are driven
    assign serial_data_pin_o       = master_on ? soft_master_data_out : 1'b0;
    assign serial_data_pin_oe_n_o  = master_on ? ~soft_master_data_out_enable :
                                     ~(slave_on & drive_low);
    assign serial_clock_pin_o      = soft_master_clock_out;
    assign serial_clock_pin_oe_n_o = ~master_on;

    // =============================================================
    // slave byte engine
    assign byte_done = slave_on & scl_fall &
                       (((state == ST_RXB) && (bit_cnt == 4'd8)) ||
                        ((state == ST_TXB) && (bit_cnt == 4'd8)));

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state                    <= ST_IDLE;
            shift                    <= 8'h00;
            bit_cnt                  <= 4'd0;
            drive_low                <= 1'b0;
            rx_push                  <= 1'b0;
            slave_transmit_direction <= 1'b0;
        end else if (clk_en_i) begin
            rx_push <= 1'b0;
            if (!slave_on) begin
                state                    <= ST_IDLE;
                drive_low                <= 1'b0;
                bit_cnt                  <= 4'd0;
                slave_transmit_direction <= 1'b0;
            end else if (stop_seen) begin
                state     <= ST_IDLE;
                drive_low <= 1'b0;
            end else if (start_seen) begin
                state     <= ST_ADDR;
                bit_cnt   <= 4'd0;
                drive_low <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_RXB: begin
                        if (scl_rise && bit_cnt != 4'd8) begin
                            shift   <= {shift[6:0], sda_now};
                            bit_cnt <= bit_cnt + 4'd1;
                        end else if (scl_fall && bit_cnt == 4'd8) begin
                            bit_cnt <= 4'd0;
                            if (state == ST_ADDR) begin
                                if (shift[7:1] == own_slave_address[6:0]) begin
                                    state                    <= ST_AACK;
                                    drive_low                <= 1'b1;
                                    slave_transmit_direction <= shift[0];
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                state     <= ST_RACK;
                                drive_low <= fifo_in_ready;
                                rx_push   <= fifo_in_ready;
                            end
                        end
                    end
                    ST_AACK, ST_RACK, ST_TACK: begin
                        if (scl_fall) begin
                            if (state == ST_TACK && sda_q) begin
                                state     <= ST_IDLE;
                                drive_low <= 1'b0;
                            end else if (slave_transmit_direction) begin
                                state     <= ST_TXB;
                                shift     <= twowire_data_reg;
                                drive_low <= ~twowire_data_reg[7];
                                bit_cnt   <= 4'd1;
                            end else begin
                                state     <= ST_RXB;
                                drive_low <= 1'b0;
                            end
                        end
                    end
                    ST_TXB: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'd8) begin
                                state     <= ST_TACK;
                                drive_low <= 1'b0;
                            end else begin
                                drive_low <= ~shift[6];
                                shift     <= {shift[6:0], 1'b0};
                                bit_cnt   <= bit_cnt + 4'd1;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // =============================================================
    // received bytes; a full buffer withholds the acknowledge
    tws_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .flush_i     (~slave_on),
        .in_valid_i  (rx_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (shift),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    // =============================================================
    // software registers
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            twowire_data_reg            <= `TWS_RST_DATA;
            own_slave_address           <= `TWS_RST_OWN;
            soft_master_data_out        <= 1'b0;
            soft_master_data_out_enable <= 1'b0;
            soft_master_clock_out       <= 1'b0;
            soft_master_data_in         <= 1'b0;
            role_select                 <= 1'b0;
            slave_interface_reset       <= 1'b0;
            byte_complete_flag          <= 1'b0;
        end else if (clk_en_i) begin
            if (hit(sfr_addr_i, `TWS_ADDR_DATA, sfr_wr_i)) begin
                twowire_data_reg <= sfr_wdata_i;
            end else if (rx_push) begin
                twowire_data_reg <= shift;
            end
            if (hit(sfr_addr_i, `TWS_ADDR_OWN, sfr_wr_i)) begin
                own_slave_address <= sfr_wdata_i;
            end
            if (hit(sfr_addr_i, `TWS_ADDR_CTRL, sfr_wr_i)) begin
                soft_master_data_out        <= sfr_wdata_i[`TWS_CTRL_MDOUT];
                soft_master_data_out_enable <= sfr_wdata_i[`TWS_CTRL_MDOE];
                soft_master_clock_out       <= sfr_wdata_i[`TWS_CTRL_MCLK];
                role_select                 <= sfr_wdata_i[`TWS_CTRL_ROLE];
                slave_interface_reset       <= sfr_wdata_i[`TWS_CTRL_SRST];
            end
            // latch data on clock high while not driving
            if (master_on && !soft_master_data_out_enable && scl_now) begin
                soft_master_data_in <= sda_now;
            end
            // set wins over the clear by a data access
            if (byte_done) begin
                byte_complete_flag <= 1'b1;
            end else if (data_acc) begin
                byte_complete_flag <= 1'b0;
            end else if (hit(sfr_addr_i, `TWS_ADDR_CTRL, sfr_wr_i)) begin
                byte_complete_flag <= sfr_wdata_i[`TWS_CTRL_DONE];
            end
        end
    end

    // =============================================================
    // read data, registered one edge after the strobe
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (clk_en_i && sfr_rd_i) begin
            case (sfr_addr_i)
                `TWS_ADDR_DATA: sfr_rdata_o <= twowire_data_reg;
                `TWS_ADDR_OWN:  sfr_rdata_o <= own_slave_address;
                `TWS_ADDR_CTRL: sfr_rdata_o <= {soft_master_data_out,
                                                soft_master_data_out_enable,
                                                soft_master_clock_out,
                                                soft_master_data_in,
                                                role_select,
                                                slave_interface_reset,
                                                slave_transmit_direction,
                                                byte_complete_flag};
                default:        sfr_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// ---- tws_regs.vh ----
// register map, field positions and reset values of the two-wire block
`ifndef TWS_REGS_VH
`define TWS_REGS_VH
// =============================================================
// special-function register addresses
`define TWS_ADDR_DATA      8'h9A
`define TWS_ADDR_OWN       8'h9B
`define TWS_ADDR_CTRL      8'hE8
// =============================================================
// control register fields
`define TWS_CTRL_MDOUT     7
`define TWS_CTRL_MDOE      6
`define TWS_CTRL_MCLK      5
`define TWS_CTRL_MDIN      4
`define TWS_CTRL_ROLE      3
`define TWS_CTRL_SRST      2
`define TWS_CTRL_TXDIR     1
`define TWS_CTRL_DONE      0
// =============================================================
// reset values
`define TWS_RST_DATA       8'h00
`define TWS_RST_OWN        8'h55
`define TWS_RST_CTRL       8'h00
`endif

// ---- tws_fifo.v ----
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module tws_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             core_clk_i,
    input  wire             reset_n_i,
    input  wire             clk_en_i,
    input  wire             flush_i,
    // filling side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // draining side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge core_clk_i) begin
        if (clk_en_i && push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else if (clk_en_i) begin
            if (flush_i) begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
                count  <= {(AW+1){1'b0}};
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
                if (push && !pop) begin
                    count <= count + 1'b1;
                end else if (pop && !push) begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule

// ---- tws_core_sva.sv ----
// concurrent checks on the two-wire block's ports
`timescale 1ns/100ps
module tws_core_sva (
    // clock and reset
    input wire       core_clk_i,
    input wire       reset_n_i,
    input wire       clk_en_i,
    // register port
    input wire [7:0] sfr_addr_i,
    input wire       sfr_wr_i,
    input wire       sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] sfr_rdata_o,
    // pins
    input wire       peripheral_select_i,
    input wire       serial_data_pin_i,
    input wire       serial_data_pin_o,
    input wire       serial_data_pin_oe_n_o,
    input wire       serial_clock_pin_i,
    input wire       serial_clock_pin_o,
    input wire       serial_clock_pin_oe_n_o,
    // received stream
    input wire       rx_valid_o,
    input wire [7:0] rx_data_o,
    input wire       rx_ready_i
);
    reg  [7:0] own_sh;
    reg  [4:0] ctl_sh;
    wire       wr_ok  = sfr_wr_i && clk_en_i;
    wire       ctl_wr = wr_ok && sfr_addr_i == 8'hE8;
    wire       master = ctl_sh[1] && !peripheral_select_i;
    // =====================================================
    // shadow of software-written bits: mdout, mdoe, mclk, role, srst
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            own_sh <= 8'h55;
            ctl_sh <= 5'h00;
        end else if (wr_ok && sfr_addr_i == 8'h9B) begin
            own_sh <= sfr_wdata_i;
        end else if (ctl_wr) begin
            ctl_sh <= {sfr_wdata_i[7:5], sfr_wdata_i[3:2]};
        end
    end
    // =====================================================
    // properties
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_read(a);
        sfr_rd_i && clk_en_i && sfr_addr_i == a;
    endsequence
    chk_pins_psel_free: assert property (peripheral_select_i |->
        serial_data_pin_oe_n_o && serial_clock_pin_oe_n_o) else $error("pins driven while shared");
    chk_clk_oe_role: assert property (!peripheral_select_i |->
        serial_clock_pin_oe_n_o == !ctl_sh[1]) else $error("clock enable not from role");
    chk_clk_out_val: assert property (master |->
        serial_clock_pin_o == ctl_sh[2]) else $error("clock pin not from control");
    chk_data_oe_master: assert property (master |->
        serial_data_pin_oe_n_o == !ctl_sh[3]) else $error("data enable not from control");
    chk_data_out_val: assert property (master && ctl_sh[3] |->
        serial_data_pin_o == ctl_sh[4]) else $error("data pin not from control");
    chk_own_addr_read: assert property (s_read(8'h9B) |=>
        sfr_rdata_o == $past(own_sh)) else $error("own address read wrong");
    chk_unmapped_read: assert property (sfr_rd_i && clk_en_i && !(sfr_addr_i inside
        {8'h9A, 8'h9B, 8'hE8}) |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
    chk_slave_rst_flush: assert property (ctl_sh[0] && !ctl_sh[1] |=>
        !rx_valid_o) else $error("buffer kept during slave reset");
    chk_rx_hold: assert property (rx_valid_o && !rx_ready_i && clk_en_i && !ctl_sh[0]
        && !ctl_sh[1] && !peripheral_select_i && !ctl_wr |=> rx_valid_o && $stable(rx_data_o))
        else $error("stalled word changed");
endmodule

// ---- tws_bus_model.sv ----
// external two-wire bus master facing the block's slave side
`timescale 1ns/100ps
module tws_bus_model (
    // resolved data line
    input  wire sda_i,
    // open-drain pulls, low pulls the line down
    output reg  scl_oe_n_o,
    output reg  sda_oe_n_o
);
    localparam real Q = 31.25;
    initial begin
        scl_oe_n_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    // =====================================================
    // one bit per 125 ns period; clock stands high between frames
    task put_bit(input logic b);
        begin
            sda_oe_n_o = b;
            #Q scl_oe_n_o = 1'b1;
            #(2*Q) scl_oe_n_o = 1'b0;
            #Q;
        end
    endtask
    task get_bit(output logic b);
        begin
            sda_oe_n_o = 1'b1;
            #Q scl_oe_n_o = 1'b1;
            #Q b = sda_i;
            #Q scl_oe_n_o = 1'b0;
            #Q;
        end
    endtask
    task start;
        begin
            #(2*Q) sda_oe_n_o = 1'b0;
            #(2*Q) scl_oe_n_o = 1'b0;
            #Q;
        end
    endtask
    task stop;
        begin
            sda_oe_n_o = 1'b0;
            #Q scl_oe_n_o = 1'b1;
            #(2*Q) sda_oe_n_o = 1'b1;
            #(2*Q);
        end
    endtask
    // msb first, ack seen as a low data line
    task write_byte(input logic [7:0] b, output logic ack);
        integer k;
        logic   a;
        begin
            for (k = 7; k >= 0; k = k - 1) put_bit(b[k]);
            get_bit(a);
            ack = !a;
        end
    endtask
    task read_byte(output logic [7:0] b, input logic ack);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) get_bit(b[k]);
            put_bit(!ack);
        end
    endtask
    task pull(input logic low);
        sda_oe_n_o = !low;
    endtask
endmodule

// ---- tws_core_tb_top.sv ----
// self-checking bench for the two-wire block
`timescale 1ns/100ps
module tws_core_tb_top;
    reg        core_clk_i, reset_n_i, clk_en_i, sfr_wr_i, sfr_rd_i;
    reg        peripheral_select_i, rx_ready_i, ack;
    reg  [7:0] sfr_addr_i, sfr_wdata_i, v;
    wire [7:0] sfr_rdata_o, rx_data_o;
    wire       rx_valid_o, sda_o, sda_oe_n, scl_o, scl_oe_n, m_scl_oe_n, m_sda_oe_n;
    // pull-ups: a released line reads high
    wire       sda = (sda_oe_n | sda_o) & m_sda_oe_n;
    wire       scl = (scl_oe_n | scl_o) & m_scl_oe_n;
    integer    fail_count = 0, num_checks = 0, cycles = 0, i;
    tws_core i_tws_core (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .peripheral_select_i(peripheral_select_i), .serial_data_pin_i(sda),
        .serial_data_pin_o(sda_o), .serial_data_pin_oe_n_o(sda_oe_n),
        .serial_clock_pin_i(scl), .serial_clock_pin_o(scl_o),
        .serial_clock_pin_oe_n_o(scl_oe_n), .rx_valid_o(rx_valid_o),
        .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i));
    tws_bus_model i_tws_bus_model (
        .sda_i(sda), .scl_oe_n_o(m_scl_oe_n), .sda_oe_n_o(m_sda_oe_n));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // =====================================================
    // hang guard, well above the fewer than two thousand cycles needed
    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            end_sim;
        end
    end
    // =====================================================
    // shared tasks
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                $display("ERROR %0s expected %h seen %h", nm, exp, got);
                fail_count = fail_count + 1;
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge core_clk_i);
            sfr_addr_i = a;
            sfr_wdata_i = d;
            sfr_wr_i = 1'b1;
            @(negedge core_clk_i);
            sfr_wr_i = 1'b0;
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] exp, input [7:0] m, input string nm);
        begin
            @(negedge core_clk_i);
            sfr_addr_i = a;
            sfr_rd_i = 1'b1;
            @(negedge core_clk_i);
            sfr_rd_i = 1'b0;
            v = sfr_rdata_o;
            chk(nm, exp, v & m);
        end
    endtask
    task settle;
        repeat (6) @(negedge core_clk_i);
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    // =====================================================
    // scenarios
    task t_reset_vals;
        begin
            rd_chk(8'h9A, 8'h00, 8'hFF, "data reset");
            rd_chk(8'h9B, 8'h55, 8'hFF, "own reset");
            rd_chk(8'hE8, 8'h00, 8'hFF, "control reset");
            rd_chk(8'h9C, 8'h00, 8'hFF, "unmapped");
            wr(8'h9B, 8'h3C);
            rd_chk(8'h9B, 8'h3C, 8'hFF, "own write");
            // a write while the enable is low must not land
            clk_en_i = 1'b0;
            wr(8'h9B, 8'h11);
            clk_en_i = 1'b1;
            rd_chk(8'h9B, 8'h3C, 8'hFF, "frozen write");
        end
    endtask
    task t_master;
        begin
            wr(8'hE8, 8'hE8);
            chk("drive pins", 8'h05, {4'h0, scl_oe_n, scl_o, sda_oe_n, sda_o});
            wr(8'hE8, 8'h28);
            chk("input pins", 8'h06, {4'h0, scl_oe_n, scl_o, sda_oe_n, sda_o});
            i_tws_bus_model.pull(1'b1);
            settle;
            rd_chk(8'hE8, 8'h00, 8'h10, "sampled low");
            i_tws_bus_model.pull(1'b0);
            settle;
            rd_chk(8'hE8, 8'h10, 8'h10, "sampled high");
            wr(8'hE8, 8'h08);
            i_tws_bus_model.pull(1'b1);
            settle;
            rd_chk(8'hE8, 8'h10, 8'h10, "held clock low");
            i_tws_bus_model.pull(1'b0);
            peripheral_select_i = 1'b1;
            @(negedge core_clk_i);
            chk("shared pins", 8'h0A, {4'h0, scl_oe_n, scl_o, sda_oe_n, sda_o});
            peripheral_select_i = 1'b0;
            wr(8'hE8, 8'h00);
            chk("slave clock", 8'h01, {7'h00, scl_oe_n});
        end
    endtask
    task t_slave_fill;
        begin
            i_tws_bus_model.start;
            i_tws_bus_model.write_byte({7'h3C, 1'b0}, ack);
            chk("address ack", 8'h01, {7'h00, ack});
            for (i = 0; i < 4; i = i + 1) begin
                i_tws_bus_model.write_byte(8'hA0 + i[7:0], ack);
                chk("data ack", 8'h01, {7'h00, ack});
            end
            rd_chk(8'hE8, 8'h01, 8'h03, "rx flag dir");
            rd_chk(8'h9A, 8'hA3, 8'hFF, "rx data");
            rd_chk(8'hE8, 8'h00, 8'h01, "flag cleared");
            i_tws_bus_model.write_byte(8'hB0, ack);
            chk("full refusal", 8'h00, {7'h00, ack});
            i_tws_bus_model.stop;
            @(negedge core_clk_i);
            for (i = 0; i < 4; i = i + 1) begin
                chk("fifo valid", 8'h01, {7'h00, rx_valid_o});
                chk("fifo data", 8'hA0 + i[7:0], rx_data_o);
                rx_ready_i = 1'b1;
                @(negedge core_clk_i);
                rx_ready_i = 1'b0;
            end
            chk("fifo empty", 8'h00, {7'h00, rx_valid_o});
        end
    endtask
    task t_mismatch;
        begin
            rd_chk(8'h9A, 8'hA3, 8'hFF, "flag clear read");
            i_tws_bus_model.start;
            i_tws_bus_model.write_byte({7'h55, 1'b0}, ack);
            i_tws_bus_model.stop;
            chk("foreign address", 8'h00, {7'h00, ack});
            rd_chk(8'hE8, 8'h00, 8'h01, "no flag");
        end
    endtask
    task t_slave_read;
        begin
            wr(8'h9A, 8'hC3);
            i_tws_bus_model.start;
            i_tws_bus_model.write_byte({7'h3C, 1'b1}, ack);
            chk("read address ack", 8'h01, {7'h00, ack});
            rd_chk(8'hE8, 8'h02, 8'h02, "tx direction");
            i_tws_bus_model.read_byte(v, 1'b0);
            i_tws_bus_model.stop;
            chk("tx byte", 8'hC3, v);
        end
    endtask
    task t_slave_rst;
        begin
            i_tws_bus_model.start;
            i_tws_bus_model.write_byte({7'h3C, 1'b0}, ack);
            i_tws_bus_model.write_byte(8'h5A, ack);
            i_tws_bus_model.stop;
            chk("byte held", 8'h01, {7'h00, rx_valid_o});
            wr(8'hE8, 8'h04);
            @(negedge core_clk_i);
            chk("flushed", 8'h00, {7'h00, rx_valid_o});
            rd_chk(8'hE8, 8'h04, 8'h06, "reset direction");
            wr(8'hE8, 8'h00);
        end
    endtask
    initial begin
        {reset_n_i, sfr_wr_i, sfr_rd_i, peripheral_select_i, rx_ready_i} = 5'h00;
        clk_en_i = 1'b1;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        reset_n_i = 1'b1;
        t_reset_vals;
        t_master;
        t_slave_fill;
        t_mismatch;
        t_slave_read;
        t_slave_rst;
        end_sim;
    end
endmodule
bind tws_core tws_core_sva i_tws_core_sva (.*);
